// file: pkg/lld_pkg.sv
package lld_pkg;

  // register map and reset values
  localparam logic [7:0] LLD_REG_POWER = 8'h00;
  localparam logic [7:0] LLD_REG_PEAK = 8'h01;
  localparam logic [7:0] LLD_POWER_RST = 8'h00;
  localparam logic [7:0] LLD_PEAK_RST = 8'h00;
  localparam int unsigned LLD_SLEEP_BIT = 0;

  // serial bus address bytes, seven-bit address plus direction
  localparam logic [7:0] LLD_ADDR_WR = 8'hEC;
  localparam logic [7:0] LLD_ADDR_RD = 8'hED;
  localparam logic [3:0] LLD_BYTE_BITS = 4'h8;
  localparam logic [3:0] LLD_LAST_BIT = 4'h7;

  // bridge polarity timing
  localparam int unsigned LLD_CLK_HZ = 125_000_000;
  localparam int unsigned LLD_LENS_FREQ_HZ = 1100;
  localparam int unsigned LLD_HALF_PERIOD_CYCLES = LLD_CLK_HZ / (2 * LLD_LENS_FREQ_HZ);
  localparam int unsigned LLD_HALF_CNT_W = 17;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_MACK = 6'h20
  } lld_bus_state_t;

endpackage

// file: pkg/lld_ctl_if.sv
`timescale 1ns/1ps
interface lld_ctl_if;
  logic active;
  logic [7:0] peak_level;
  modport src (output active, output peak_level);
  modport snk (input active, input peak_level);
endinterface

// file: rtl/lld_bridge.sv
`timescale 1ns/1ps
module lld_bridge #(
  parameter int unsigned HALF_PERIOD_CYCLES = lld_pkg::LLD_HALF_PERIOD_CYCLES
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  lld_ctl_if.snk ctl,
  output logic [7:0] lens_a_o,
  output logic [7:0] lens_b_o
);
  import lld_pkg::*;

  localparam logic [LLD_HALF_CNT_W-1:0] HALF_LAST = LLD_HALF_CNT_W'(HALF_PERIOD_CYCLES - 1);

  logic [LLD_HALF_CNT_W-1:0] cnt_reg;
  logic pol_reg;
  wire logic half_done = (cnt_reg == HALF_LAST);
  wire logic [LLD_HALF_CNT_W-1:0] cnt_next = half_done ? '0 : cnt_reg + 1'b1;
  // code zero already yields zero drive, no special case needed
  wire logic [7:0] a_next = (ctl.active && !pol_reg) ? ctl.peak_level : 8'h00; // see RULE2 see RULE16
  wire logic [7:0] b_next = (ctl.active && pol_reg) ? ctl.peak_level : 8'h00; // see RULE2 see RULE16

  always_ff @(posedge clk_i)
  begin
    if (reset_i || !ctl.active)
    begin
      cnt_reg <= '0;
      pol_reg <= 1'b0;
      lens_a_o <= 8'h00;
      lens_b_o <= 8'h00;
    end
    else
    begin
      cnt_reg <= cnt_next;
      pol_reg <= half_done ? ~pol_reg : pol_reg; // see RULE3
      lens_a_o <= a_next;
      lens_b_o <= b_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_toggle;
    @(posedge clk_i) disable iff (reset_i)
    (ctl.active && half_done) |=> (pol_reg != $past(pol_reg) || !ctl.active);
  endproperty
  a_toggle: assert property (p_toggle) else $error("bridge polarity did not toggle"); // see RULE3

  property p_level;
    @(posedge clk_i) disable iff (reset_i)
    (ctl.active && $stable(ctl.peak_level)) ##1 ctl.active
      |-> ((lens_a_o | lens_b_o) == $past(ctl.peak_level)) && ((lens_a_o & lens_b_o) == 8'h00);
  endproperty
  a_level: assert property (p_level) else $error("lens level differs from peak code"); // see RULE2

  property p_quiet;
    @(posedge clk_i) disable iff (reset_i)
    !ctl.active |=> (lens_a_o == 8'h00 && lens_b_o == 8'h00);
  endproperty
  a_quiet: assert property (p_quiet) else $error("lens outputs active in sleep"); // see RULE6

endmodule // lld_bridge

// file: rtl/lld_top.sv
`timescale 1ns/1ps
// What this block does
// RULE1 - power-on reset clears all registers and leaves the device asleep.
// RULE2 - both lens outputs take their peak amplitude from the peak level register.
// RULE3 - output bridge polarity toggles at about 1.1 kHz.
// RULE4 - enable pin low holds registers in reset and ignores the serial bus.
// RULE5 - controller drives enable low for shutdown, high for operation.
// RULE6 - enable high with sleep bit zero means sleep, lens outputs inactive.
// RULE7 - sleep bit is power register bit 0, reset 0, 1 means normal.
// RULE8 - sleep entry or exit keeps register contents; only reset clears them.
// RULE9 - master writes zeros to reserved power register bits 7 to 1.
// RULE10 - master starts all transfers and makes the serial clock.
// RULE11 - data line is input and open-drain output, never driven high.
// RULE12 - pointer 0x00 selects power register, 0x01 selects peak level.
// RULE13 - answer address byte 0xEC for write and 0xED for read.
// RULE14 - first written byte is the pointer; a stop then only stores it.
// RULE15 - pointer advances by one after each data byte written or read.
// RULE16 - eight-bit peak code resets to 0x00, zero gives zero output, linear above.
// RULE17 - acknowledge each received byte; stop sending after a master not-acknowledge.
module lld_top #(
  parameter int unsigned HALF_PERIOD_CYCLES = lld_pkg::LLD_HALF_PERIOD_CYCLES
)
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic EN_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic [7:0] LENS_OUTPUT_A_O,
  output logic [7:0] LENS_OUTPUT_B_O
);
  import lld_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage is read only by the second
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic en_meta_reg, en_sync_reg;

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end
    else
    begin
      scl_meta_reg <= SCL_I;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= SDA_I;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      en_meta_reg <= EN_I;
      en_sync_reg <= en_meta_reg;
    end
  end

  wire logic scl_rise = scl_sync_reg && !scl_prev_reg;
  wire logic scl_fall = !scl_sync_reg && scl_prev_reg;
  wire logic bus_start = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
  wire logic bus_stop = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // serial slave state
  lld_bus_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] ptr_reg, ptr_next;
  logic ptr_phase_reg, ptr_phase_next;
  logic rw_reg, rw_next;
  logic sda_oe_reg, sda_oe_next;
  logic [7:0] power_reg, power_next;
  logic [7:0] peak_reg, peak_next;
  logic wr_en;

  wire logic [7:0] shift_in = {shift_reg[6:0], sda_sync_reg};
  wire logic byte_end = scl_fall && (bit_cnt_reg == LLD_BYTE_BITS);
  wire logic sel_power = (ptr_reg == LLD_REG_POWER); // see RULE12
  wire logic sel_peak = (ptr_reg == LLD_REG_PEAK); // see RULE12
  // unmapped pointers read as zero and swallow writes
  wire logic [7:0] rd_data = sel_power ? power_reg : (sel_peak ? peak_reg : 8'h00);
  wire logic [7:0] ptr_inc = ptr_reg + 8'h01;

  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    ptr_phase_next = ptr_phase_reg;
    rw_next = rw_reg;
    sda_oe_next = sda_oe_reg;
    wr_en = 1'b0;
    if (bus_stop)
    begin
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
    end
    else if (bus_start)
    begin
      state_next = ST_ADDR;
      bit_cnt_next = 4'h0;
      sda_oe_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          sda_oe_next = 1'b0;
        end
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            shift_next = shift_in;
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          else if (byte_end && state_reg == ST_ADDR)
          begin
            if (shift_reg == LLD_ADDR_WR || shift_reg == LLD_ADDR_RD) // see RULE13
            begin
              rw_next = shift_reg[0];
              ptr_phase_next = !shift_reg[0]; // see RULE14
              state_next = ST_ACK;
              sda_oe_next = 1'b1; // see RULE17
            end
            else
            begin
              state_next = ST_IDLE;
            end
          end
          else if (byte_end)
          begin
            if (ptr_phase_reg)
            begin
              ptr_next = shift_reg; // see RULE14
              ptr_phase_next = 1'b0;
            end
            else
            begin
              wr_en = 1'b1;
              ptr_next = ptr_inc; // see RULE15
            end
            state_next = ST_ACK;
            sda_oe_next = 1'b1; // see RULE17
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_next = 4'h0;
            if (rw_reg)
            begin
              state_next = ST_TX;
              tx_next = rd_data;
              sda_oe_next = !rd_data[7]; // see RULE11
            end
            else
            begin
              state_next = ST_RX;
              sda_oe_next = 1'b0;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == LLD_LAST_BIT)
            begin
              state_next = ST_MACK;
              sda_oe_next = 1'b0;
              ptr_next = ptr_inc; // see RULE15
            end
            else
            begin
              tx_next = {tx_reg[6:0], 1'b0};
              sda_oe_next = !tx_reg[6];
            end
          end
        end
        ST_MACK:
        begin
          // master answer sampled on the rising edge; a high level ends the read
          if (scl_rise)
          begin
            state_next = sda_sync_reg ? ST_IDLE : ST_ACK; // see RULE17
          end
        end
        default:
        begin
          state_next = ST_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  // reserved power bits are stored as written
  assign power_next = (wr_en && sel_power) ? shift_reg : power_reg; // see RULE7
  assign peak_next = (wr_en && sel_peak) ? shift_reg : peak_reg; // see RULE16

  // shutdown holds the whole slave and its registers cleared, so the bus is ignored
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I || !en_sync_reg) // see RULE1 see RULE4
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= LLD_REG_POWER;
      ptr_phase_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      power_reg <= LLD_POWER_RST;
      peak_reg <= LLD_PEAK_RST;
    end
    else
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      ptr_phase_reg <= ptr_phase_next;
      rw_reg <= rw_next;
      sda_oe_reg <= sda_oe_next;
      power_reg <= power_next;
      peak_reg <= peak_next;
    end
  end

  assign SDA_O = 1'b0; // see RULE11
  assign SDA_OE_O = sda_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // lens bridge; sleep changes only the bridge, never the registers
  lld_ctl_if ctl ();
  assign ctl.active = en_sync_reg && power_reg[LLD_SLEEP_BIT]; // see RULE6 see RULE8
  assign ctl.peak_level = peak_reg; // see RULE2

  lld_bridge #(
    .HALF_PERIOD_CYCLES(HALF_PERIOD_CYCLES)
  ) u_bridge (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ctl(ctl),
    .lens_a_o(LENS_OUTPUT_A_O),
    .lens_b_o(LENS_OUTPUT_B_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  property p_por;
    @(posedge CLK_I) RESET_I |=> (power_reg == LLD_POWER_RST && peak_reg == LLD_PEAK_RST && !ctl.active);
  endproperty
  a_por: assert property (p_por) else $error("registers not cleared by reset"); // see RULE1

  property p_shutdown;
    @(posedge CLK_I) disable iff (RESET_I)
    !en_sync_reg |=> (power_reg == LLD_POWER_RST && peak_reg == LLD_PEAK_RST && !SDA_OE_O && state_reg == ST_IDLE);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown did not hold reset state"); // see RULE4

  property p_open_drain;
    @(posedge CLK_I) disable iff (RESET_I)
    // the line may only be pulled while acknowledging or sending a data bit
    SDA_OE_O |-> (!SDA_O && (state_reg == ST_ACK || state_reg == ST_TX));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data line driven high"); // see RULE11

  property p_addr_ack;
    @(posedge CLK_I) disable iff (RESET_I)
    (en_sync_reg && !bus_stop && !bus_start && state_reg == ST_ADDR && byte_end)
      |=> ((state_reg == ST_ACK && SDA_OE_O) == ($past(shift_reg) == LLD_ADDR_WR || $past(shift_reg) == LLD_ADDR_RD));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address byte answered wrongly"); // see RULE13

  property p_ptr_store;
    @(posedge CLK_I) disable iff (RESET_I)
    (en_sync_reg && !bus_stop && !bus_start && state_reg == ST_RX && byte_end && ptr_phase_reg)
      |=> (ptr_reg == $past(shift_reg) && $stable(power_reg) && $stable(peak_reg));
  endproperty
  a_ptr_store: assert property (p_ptr_store) else $error("pointer byte not stored alone"); // see RULE14

  property p_ptr_advance;
    @(posedge CLK_I) disable iff (RESET_I)
    (en_sync_reg && wr_en) |=> (ptr_reg == $past(ptr_reg) + 8'h01);
  endproperty
  a_ptr_advance: assert property (p_ptr_advance) else $error("pointer did not advance"); // see RULE15

  property p_decode;
    @(posedge CLK_I) disable iff (RESET_I)
    (en_sync_reg && wr_en && ptr_reg == LLD_REG_PEAK) |=> (peak_reg == $past(shift_reg) && $stable(power_reg));
  endproperty
  a_decode: assert property (p_decode) else $error("peak register write misdecoded"); // see RULE12

  property p_sleep_keep;
    @(posedge CLK_I) disable iff (RESET_I)
    (en_sync_reg && wr_en && sel_power) |=> $stable(peak_reg);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("sleep change disturbed peak register"); // see RULE8

  property p_nack_stop;
    @(posedge CLK_I) disable iff (RESET_I)
    (en_sync_reg && !bus_stop && !bus_start && state_reg == ST_MACK && scl_rise && sda_sync_reg)
      |=> (state_reg == ST_IDLE && !SDA_OE_O) [*2];
  endproperty
  a_nack_stop: assert property (p_nack_stop) else $error("data still sent after not-acknowledge"); // see RULE17

endmodule // lld_top

// file: verification/lld_i2c_host.sv
`timescale 1ns/1ps
module lld_i2c_host
(
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  // clock rests high between frames; the data line is only ever pulled, never driven high
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  ////////////////////////////////////////
  // data changes mid-low, sampled on the rising clock: 125 ns per bit
  task automatic bit_x(input logic b, output logic r);
    #31 sda_pull_o = !b;
    #31.5 scl_o = 1'b1;
    r = sda_i;
    #62.5 scl_o = 1'b0;
  endtask
  task automatic start_c();
    sda_pull_o = 1'b0;
    #31 scl_o = 1'b1;
    #62.5 sda_pull_o = 1'b1;
    #62.5 scl_o = 1'b0;
  endtask
  task automatic stop_c();
    #31 sda_pull_o = 1'b1;
    #31.5 scl_o = 1'b1;
    #62.5 sda_pull_o = 1'b0;
    #62.5;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nack, r);
  endtask
endmodule // lld_i2c_host

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import lld_pkg::*;
  localparam int HP = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic scl;
  logic pull;
  logic sda_o;
  logic sda_oe;
  logic sda_w;
  logic [7:0] lens_a;
  logic [7:0] lens_b;
  logic [7:0] mdl_reg [2];
  logic [7:0] mdl_ptr;
  logic [7:0] pk;
  logic a;
  logic [31:0] rng = 32'h0000_8E6D;
  int miscompares = 0;
  int checks_done = 0;
  always #4 clk = !clk;
  // pull-up wins unless someone pulls low
  assign sda_w = (sda_oe ? sda_o : 1'b1) && !pull;
  lld_top #(.HALF_PERIOD_CYCLES(HP)) u_lld_top (.CLK_I(clk), .RESET_I(rst), .EN_I(en), .SCL_I(scl),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .LENS_OUTPUT_A_O(lens_a), .LENS_OUTPUT_B_O(lens_b));
  lld_i2c_host host (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda_w));
  ////////////////////////////////////////
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic mdl_clear();
    mdl_reg = '{8'h00, 8'h00};
    mdl_ptr = 8'h00;
  endtask
  // with the enable low no byte may be acknowledged and the model stays cleared
  task automatic bus_wr(input logic [7:0] ptr, input int n, input logic [7:0] d0, input logic [7:0] d1);
    host.start_c();
    host.wr_byte(LLD_ADDR_WR, a);
    chk_bit(a, en);
    host.wr_byte(ptr, a);
    chk_bit(a, en);
    if (en)
      mdl_ptr = ptr;
    for (int i = 0; i < n; i++)
    begin
      host.wr_byte(i ? d1 : d0, a);
      chk_bit(a, en);
      if (en && mdl_ptr < 8'h02)
        mdl_reg[mdl_ptr[0]] = i ? d1 : d0;
      if (en)
        mdl_ptr++;
    end
    host.stop_c();
  endtask
  task automatic bus_rd(input int n);
    logic [7:0] d;
    host.start_c();
    host.wr_byte(LLD_ADDR_RD, a);
    chk_bit(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      host.rd_byte(i == n - 1, d);
      chk_byte(d, mdl_ptr < 8'h02 ? mdl_reg[mdl_ptr[0]] : 8'h00);
      mdl_ptr++;
    end
    #40;
    chk_bit(sda_oe, 1'b0);
    chk_bit(sda_o, 1'b0);
    host.stop_c();
  endtask
  // outputs must show the peak on exactly one terminal, swapping every HP clocks
  task automatic chk_lens(input logic on);
    logic [7:0] a0;
    int n;
    pk = on ? mdl_reg[1] : 8'h00;
    step();
    chk_bit((lens_a === pk && lens_b === 8'h00) || (lens_a === 8'h00 && lens_b === pk), 1'b1);
    if (on)
    begin
      a0 = lens_a;
      for (n = 0; n < 40 && lens_a === a0; n++) step();
      chk_bit(n < 40, 1'b1);
      a0 = lens_a;
      for (n = 0; n < 40 && lens_a === a0; n++) step();
      chk_byte(n[7:0], HP[7:0]);
    end
  endtask
  task automatic test_done();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    mdl_clear();
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    en = 1'b1;
    chk_lens(1'b0);
    repeat (4) step();
    bus_rd(2);
    bus_wr(LLD_REG_PEAK, 1, rnd() | 8'h01, 8'h00);
    bus_wr(LLD_REG_POWER, 0, 8'h00, 8'h00);
    bus_wr(LLD_REG_PEAK, 0, 8'h00, 8'h00);
    bus_rd(1);
    // reserved power bits written as zeros
    bus_wr(LLD_REG_POWER, 2, 8'h01, rnd() | 8'h01);
    chk_lens(1'b1);
    // unmapped pointer drops the byte, then wraps onto the power register
    bus_wr(8'hFF, 2, 8'h55, 8'h00);
    chk_lens(1'b0);
    bus_wr(LLD_REG_POWER, 0, 8'h00, 8'h00);
    bus_rd(3);
    host.start_c();
    host.wr_byte(8'hEE, a);
    chk_bit(a, 1'b0);
    host.stop_c();
    bus_wr(LLD_REG_POWER, 1, 8'h01, 8'h00);
    chk_lens(1'b1);
    en = 1'b0;
    mdl_clear();
    repeat (5) step();
    chk_lens(1'b0);
    bus_wr(LLD_REG_PEAK, 1, 8'h22, 8'h00);
    en = 1'b1;
    repeat (5) step();
    bus_rd(2);
    test_done();
  end
endmodule // testbench
